// file: dcec_pkg.sv
// Package of constants and carrier types for the DMA channel event control block.
package dcec_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_EVENT_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CHANNEL_CTRL  = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS    = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK      = 8'h0C;

    // ------------------------------------------------------------------
    // Event control field positions
    // ------------------------------------------------------------------
    localparam int ABORT_SEL_LSB  = 16;
    localparam int START_SEL_LSB  = 8;
    localparam int FORCE_BIT      = 7;
    localparam int SW_ABORT_BIT   = 6;
    localparam int PAT_EN_BIT     = 5;
    localparam int START_EN_BIT   = 4;
    localparam int ABORT_EN_BIT   = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SEL_RESET   = 8'hFF;
    localparam logic [2:0] EN_RESET    = 3'h0;

    // ------------------------------------------------------------------
    // Channel control and interrupt status layout
    // ------------------------------------------------------------------
    localparam int CHAN_EN_BIT    = 0;
    localparam int BUSY_BIT       = 1;
    localparam int ST_ABORT_BIT   = 0;
    localparam int ST_START_BIT   = 1;
    localparam int ST_W           = 2;

    typedef struct packed {
        logic [7:0] abort_irq_select;
        logic [7:0] start_irq_select;
        logic       pattern_abort_enable;
        logic       start_request_enable;
        logic       abort_request_enable;
    } dcec_cfg_t;

    typedef struct packed {
        logic start;
        logic abort;
        logic abort_is_pattern;
    } dcec_evt_t;

    typedef enum logic [1:0] {
        DCEC_IDLE  = 2'b00,
        DCEC_BUSY  = 2'b01
    } dcec_state_t;

endpackage

// file: dcec_apb_slave.sv
// APB slave front end: decodes one transfer into a write strobe and a read strobe.
`timescale 1ns/1ps
`default_nettype none
module dcec_apb_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    output logic             pready,
    output logic             pslverr,
    output logic             wr_stb,
    output logic             rd_stb,
    input  wire logic        addr_ok
);
    // Single-cycle access phase: the slave answers at the first access edge.
    // Read data is captured at the setup edge, so it stands in flip-flops
    // for the whole access phase and the master can take it at the ready edge.
    assign pready  = 1'b1;
    assign wr_stb  = psel & penable & pwrite & ce;
    assign rd_stb  = psel & ~penable & ~pwrite & ce;
    assign pslverr = psel & penable & ~addr_ok;
endmodule
`default_nettype wire

// file: dcec_irq_match.sv
// Decodes an interrupt request vector against the start and abort selectors.
`timescale 1ns/1ps
`default_nettype none
module dcec_irq_match (
    input  wire logic                  irq_valid,
    input  wire logic [255:0]          irq_lines,
    input  wire dcec_pkg::dcec_cfg_t   cfg,
    output logic                       start_hit,
    output logic                       abort_hit
);
    // An asserted request line whose number equals the selector counts only while irq_valid and its request enable are high.
    assign start_hit = irq_valid & irq_lines[cfg.start_irq_select]
                       & cfg.start_request_enable;
    assign abort_hit = irq_valid & irq_lines[cfg.abort_irq_select]
                       & cfg.abort_request_enable;
endmodule
`default_nettype wire

// file: dcec_top.sv
// Event control for one DMA channel: start and abort triggers, APB registers, interrupt.
//
// What this block does
// - An interrupt equal to the 8-bit abort selector in bits 23:16 aborts the transfer and sets the abort flag when abort on request is enabled.
// - An interrupt equal to the 8-bit start selector in bits 15:8 begins a transfer when start on request is enabled and the channel enable is set.
// - Writing one to bit 7 forces a transfer to begin at once, and the bit reads as zero.
// - Writing one to bit 6 aborts the current transfer, and the bit reads as zero.
// - With bit 5 set a pattern match aborts the transfer and clears the channel enable, otherwise it has no effect.
// - With bit 4 set and the channel enable set a matching start interrupt begins a cell transfer, otherwise it is ignored.
// - With bit 3 set a matching abort interrupt aborts the transfer, otherwise it is ignored.
// - Bits 31:24 and 2:0 of the event control register read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module dcec_top (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          irq_valid,
    input  wire logic [255:0]  irq_lines,
    input  wire logic          pattern_match,
    input  wire logic          transfer_done,
    output logic               transfer_start,
    output logic               transfer_abort,
    output logic               channel_busy,
    output logic               irq
);
    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    dcec_pkg::dcec_cfg_t   cfg;
    dcec_pkg::dcec_cfg_t   next_cfg;
    logic                  channel_enable;
    logic                  next_channel_enable;
    logic [dcec_pkg::ST_W-1:0] status;
    logic [dcec_pkg::ST_W-1:0] next_status;
    logic [dcec_pkg::ST_W-1:0] mask;
    logic [dcec_pkg::ST_W-1:0] next_mask;
    dcec_pkg::dcec_state_t state;
    dcec_pkg::dcec_state_t next_state;
    logic [31:0]           next_prdata;
    logic                  next_start;
    logic                  next_abort;

    logic                  wr_stb;
    logic                  rd_stb;
    logic                  addr_ok;
    logic                  start_hit;
    logic                  abort_hit;
    logic                  wr_ec;
    logic                  force_wr;
    logic                  sw_abort_wr;
    logic                  pat_abort;
    dcec_pkg::dcec_evt_t   evt;
    logic [31:0]           ec_read;

    // ------------------------------------------------------------------
    // Bus and trigger decode
    // ------------------------------------------------------------------
    assign addr_ok = (paddr == dcec_pkg::OFF_EVENT_CONTROL) || (paddr == dcec_pkg::OFF_CHANNEL_CTRL)
                     || (paddr == dcec_pkg::OFF_IRQ_STATUS) || (paddr == dcec_pkg::OFF_IRQ_MASK);

    dcec_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .pslverr (pslverr),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb),
        .addr_ok (addr_ok)
    );

    dcec_irq_match u_match (
        .irq_valid (irq_valid),
        .irq_lines (irq_lines),
        .cfg       (cfg),
        .start_hit (start_hit),
        .abort_hit (abort_hit)
    );

    assign wr_ec       = wr_stb && (paddr == dcec_pkg::OFF_EVENT_CONTROL);
    // The force and abort bits live in byte lane 0 and are never stored.
    assign force_wr    = wr_ec && pstrb[0] && pwdata[dcec_pkg::FORCE_BIT];
    assign sw_abort_wr = wr_ec && pstrb[0] && pwdata[dcec_pkg::SW_ABORT_BIT];
    assign pat_abort   = pattern_match && cfg.pattern_abort_enable;

    // Abort outranks start, so a clash never begins a new transfer.
    assign evt.abort            = ce && (abort_hit || sw_abort_wr || pat_abort);
    assign evt.abort_is_pattern = ce && pat_abort;
    assign evt.start            = ce && !evt.abort
                                  && (force_wr || (start_hit && channel_enable));

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_cfg            = cfg;
        next_channel_enable = channel_enable;
        next_mask           = mask;
        next_status         = status;
        next_state          = state;
        next_start          = 1'b0;
        next_abort          = 1'b0;
        if (wr_ec) begin
            if (pstrb[2]) begin
                next_cfg.abort_irq_select = pwdata[dcec_pkg::ABORT_SEL_LSB +: 8];
            end
            if (pstrb[1]) begin
                next_cfg.start_irq_select = pwdata[dcec_pkg::START_SEL_LSB +: 8];
            end
            if (pstrb[0]) begin
                next_cfg.pattern_abort_enable = pwdata[dcec_pkg::PAT_EN_BIT];
                next_cfg.start_request_enable = pwdata[dcec_pkg::START_EN_BIT];
                next_cfg.abort_request_enable = pwdata[dcec_pkg::ABORT_EN_BIT];
            end
        end
        if (wr_stb && (paddr == dcec_pkg::OFF_CHANNEL_CTRL) && pstrb[0]) begin
            next_channel_enable = pwdata[dcec_pkg::CHAN_EN_BIT];
        end
        if (wr_stb && (paddr == dcec_pkg::OFF_IRQ_MASK) && pstrb[0]) begin
            next_mask = pwdata[dcec_pkg::ST_W-1:0];
        end
        if (wr_stb && (paddr == dcec_pkg::OFF_IRQ_STATUS) && pstrb[0]) begin
            next_status = status & ~pwdata[dcec_pkg::ST_W-1:0];
        end
        if (evt.abort_is_pattern) begin
            next_channel_enable = 1'b0;
        end
        // Hardware set is applied after the clear so a same-cycle event survives.
        if (evt.abort) begin
            next_status[dcec_pkg::ST_ABORT_BIT] = 1'b1;
            next_abort = 1'b1;
        end
        if (evt.start) begin
            next_status[dcec_pkg::ST_START_BIT] = 1'b1;
            next_start = 1'b1;
        end
        case (state)
            dcec_pkg::DCEC_IDLE: begin
                if (evt.start) begin
                    next_state = dcec_pkg::DCEC_BUSY;
                end
            end
            dcec_pkg::DCEC_BUSY: begin
                if (evt.abort || transfer_done) begin
                    next_state = dcec_pkg::DCEC_IDLE;
                end
            end
            default: begin
                next_state = dcec_pkg::DCEC_IDLE;
            end
        endcase
        if (!ce) begin
            next_start = transfer_start;
            next_abort = transfer_abort;
        end
    end

    // Unimplemented bits stay at zero on read.
    assign ec_read = {8'h00, cfg.abort_irq_select, cfg.start_irq_select, 2'b00,
                      cfg.pattern_abort_enable, cfg.start_request_enable,
                      cfg.abort_request_enable, 3'b000};

    always_comb begin
        next_prdata = prdata;
        if (rd_stb) begin
            case (paddr)
                dcec_pkg::OFF_EVENT_CONTROL: next_prdata = ec_read;
                dcec_pkg::OFF_CHANNEL_CTRL:  next_prdata = {30'h0, channel_busy, channel_enable};
                dcec_pkg::OFF_IRQ_STATUS:    next_prdata = {30'h0, status};
                dcec_pkg::OFF_IRQ_MASK:      next_prdata = {30'h0, mask};
                default:                     next_prdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg            <= '{dcec_pkg::SEL_RESET, dcec_pkg::SEL_RESET, 1'b0, 1'b0, 1'b0};
            channel_enable <= 1'b0;
            status         <= '0;
            mask           <= '0;
            state          <= dcec_pkg::DCEC_IDLE;
            transfer_start <= 1'b0;
            transfer_abort <= 1'b0;
            prdata         <= 32'h0;
        end else begin
            transfer_start <= next_start;
            transfer_abort <= next_abort;
            if (ce) begin
                cfg            <= next_cfg;
                channel_enable <= next_channel_enable;
                status         <= next_status;
                mask           <= next_mask;
                state          <= next_state;
                prdata         <= next_prdata;
            end
        end
    end

    assign channel_busy = (state == dcec_pkg::DCEC_BUSY);
    assign irq          = |(status & mask);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_abort_irq_hit: assert property (
        (ce && irq_valid && cfg.abort_request_enable && irq_lines[cfg.abort_irq_select])
        |=> (transfer_abort && status[dcec_pkg::ST_ABORT_BIT]))
        else $error("Abort interrupt did not abort the channel.");
    a_start_irq_hit: assert property (
        (ce && irq_valid && cfg.start_request_enable && irq_lines[cfg.start_irq_select]
         && channel_enable && !transfer_abort && !evt.abort) |=> transfer_start)
        else $error("Start interrupt did not begin a transfer.");
    a_force_start: assert property (
        (wr_ec && pstrb[0] && pwdata[dcec_pkg::FORCE_BIT] && !evt.abort) |=> transfer_start)
        else $error("Forced transfer did not start.");
    a_sw_abort: assert property (
        (wr_ec && pstrb[0] && pwdata[dcec_pkg::SW_ABORT_BIT]) |=> transfer_abort)
        else $error("Software abort had no effect.");
    a_pattern_abort: assert property (
        (ce && pattern_match && cfg.pattern_abort_enable) |=> (!channel_enable && transfer_abort))
        else $error("Pattern abort did not clear the channel enable.");
    a_start_masked: assert property (
        (ce && !cfg.start_request_enable && !wr_ec) |=> !transfer_start)
        else $error("Disabled start interrupt began a transfer.");
    a_abort_masked: assert property (
        (ce && !cfg.abort_request_enable && !pattern_match && !wr_ec) |=> !transfer_abort)
        else $error("Disabled abort interrupt aborted a transfer.");
    a_reserved_zero: assert property (
        (rd_stb && paddr == dcec_pkg::OFF_EVENT_CONTROL) |=> (prdata[31:24] == 8'h00
        && prdata[2:0] == 3'b000 && prdata[7:6] == 2'b00))
        else $error("Unimplemented event control bits read nonzero.");
    a_clash_abort: assert property (
        (ce && evt.abort) |=> (transfer_abort && !transfer_start))
        else $error("Start won over a same-cycle abort.");
    a_disabled_drop: assert property (
        (ce && !channel_enable && !wr_ec) |=> !transfer_start)
        else $error("Start taken while the channel was disabled.");

    c_irq_start: cover property (ce && start_hit && channel_enable);
    c_irq_abort: cover property (ce && abort_hit && channel_busy);
    c_clash:     cover property (ce && evt.abort && start_hit && channel_enable);
    c_irq_out:   cover property (irq);
endmodule
`default_nettype wire

// file: dcec_engine_model.sv
// Behavioural model of the channel transfer engine that sits behind the event control block.
`timescale 1ns/1ps
`default_nettype none
module dcec_engine_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       transfer_start,
    input  wire logic       transfer_abort,
    input  wire logic [7:0] done_wait,
    input  wire logic       pat_req,
    output logic            transfer_done,
    output logic            pattern_match
);
    int left;

    // A match is only reported while a cell is moving, as the real engine would do.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left          <= 0;
            transfer_done <= 1'b0;
            pattern_match <= 1'b0;
        end else begin
            transfer_done <= (left == 1);
            pattern_match <= pat_req && (left != 0);
            if (transfer_abort) begin
                left <= 0;
            end else if (transfer_start) begin
                left <= int'(done_wait) + 1;
            end else if (left != 0) begin
                left <= left - 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: dcec_top_tb.sv
// Self-checking testbench for the DMA channel event control block.
`timescale 1ns/1ps
`default_nettype none
module dcec_top_tb;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic [7:0]   paddr, done_wait;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   pstrb;
    logic         irq_valid, pattern_match, transfer_done, pat_req;
    logic         transfer_start, transfer_abort, channel_busy, irq;
    logic [255:0] irq_lines;
    int           n_mismatch, comparisons, n_start, n_abort;

    logic         ce;

    dcec_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_valid(irq_valid), .irq_lines(irq_lines), .pattern_match(pattern_match),
        .transfer_done(transfer_done), .transfer_start(transfer_start),
        .transfer_abort(transfer_abort), .channel_busy(channel_busy), .irq(irq));

    dcec_engine_model eng (.pclk(pclk), .presetn(presetn), .transfer_start(transfer_start),
        .transfer_abort(transfer_abort), .done_wait(done_wait), .pat_req(pat_req),
        .transfer_done(transfer_done), .pattern_match(pattern_match));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Counted on the falling edge, where the one-cycle pulses are settled.
    always @(negedge pclk) begin
        if (transfer_start === 1'b1) n_start++;
        if (transfer_abort === 1'b1) n_abort++;
    end

    // ------------------------------------------------------------------
    // Shared bus, event and comparison tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Read data and the error flag are taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
        end
        slverr  = pslverr;
        if (!wr) begin
            rd = prdata;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic fire(input int n);
        @(posedge pclk);
        irq_valid <= 1'b1;
        irq_lines <= 256'(1) << n;
        @(posedge pclk);
        irq_valid <= 1'b0;
        irq_lines <= '0;
        idle(2);
    endtask

    task automatic pat;
        @(posedge pclk);
        pat_req <= 1'b1;
        @(posedge pclk);
        pat_req <= 1'b0;
        idle(3);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdck(dcec_pkg::OFF_EVENT_CONTROL, 32'h00FFFF00);
        rdck(dcec_pkg::OFF_IRQ_STATUS, 32'h0);
    endtask

    task automatic t_force_and_abort;
        int s, a;
        s = n_start;
        a = n_abort;
        wr(8'h00, 32'hFFFFFFFF);
        idle(2);
        chk(32'(n_start - s), 32'h0);
        chk(32'(n_abort - a), 32'h1);
        rdck(8'h00, 32'h00FFFF38);
    endtask

    task automatic t_force;
        int s;
        s = n_start;
        wr(8'h00, 32'h00FFFF80);
        idle(1);
        chk(32'(n_start - s), 32'h1);
        chk(32'(channel_busy), 32'h1);
        idle(25);
        chk(32'(channel_busy), 32'h0);
    endtask

    task automatic t_irq_start;
        int s;
        done_wait <= 8'h01;
        wr(8'h00, 32'h00FF0510);
        wr(8'h04, 32'h0);
        s = n_start;
        fire(5);
        chk(32'(n_start - s), 32'h0);
        wr(8'h04, 32'h1);
        fire(5);
        chk(32'(n_start - s), 32'h1);
        idle(4);
        fire(6);
        chk(32'(n_start - s), 32'h1);
        wr(8'h00, 32'h00FF0500);
        fire(5);
        chk(32'(n_start - s), 32'h1);
        done_wait <= 8'h14;
    endtask

    task automatic t_irq_abort;
        int a;
        wr(8'h00, 32'h00FF8088);
        wr(8'h08, 32'h3);
        a = n_abort;
        fire(255);
        chk(32'(n_abort - a), 32'h1);
        rdck(8'h08, 32'h1);
        wr(8'h00, 32'h00FF8080);
        fire(255);
        chk(32'(n_abort - a), 32'h1);
        idle(25);
    endtask

    task automatic t_pattern;
        int a;
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h00FFFFA0);
        a = n_abort;
        pat();
        chk(32'(n_abort - a), 32'h1);
        rdck(8'h04, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h00FFFF80);
        pat();
        chk(32'(n_abort - a), 32'h1);
        // The forced transfer is still moving, so busy reads one beside the enable.
        rdck(8'h04, 32'h3);
        idle(25);
    endtask

    task automatic t_same_cycle;
        int s, a;
        wr(8'h00, 32'h00090918);
        s = n_start;
        a = n_abort;
        fire(9);
        chk(32'(n_start - s), 32'h0);
        chk(32'(n_abort - a), 32'h1);
    endtask

    // With the clock enable low an access completes but changes nothing.
    task automatic t_freeze;
        @(posedge pclk);
        ce <= 1'b0;
        wr(8'h0C, 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
        rdck(8'h0C, 32'h1);
    endtask

    task automatic t_irq_out;
        wr(8'h08, 32'h3);
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h00070708);
        fire(7);
        chk(32'(irq), 32'h0);
        wr(8'h0C, 32'h1);
        idle(1);
        chk(32'(irq), 32'h1);
        wr(8'h08, 32'h1);
        idle(1);
        chk(32'(irq), 32'h0);
        rdck(8'h10, 32'h0);
        chk(32'(slverr), 32'h1);
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end

    initial begin
        presetn   = 1'b0;
        ce        = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        pstrb     = 4'hF;
        irq_valid = 1'b0;
        irq_lines = '0;
        pat_req   = 1'b0;
        done_wait = 8'h14;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_force_and_abort();
        t_force();
        t_irq_start();
        t_irq_abort();
        t_pattern();
        t_same_cycle();
        t_irq_out();
        t_freeze();
        close_out();
    end
endmodule
`default_nettype wire
